// ---- hw/ars_sequencer.sv ----
// Auto restart sequencer: APB registers, trip watch, restart state machine and interrupt.
`include "ars_regs.svh"
module ars_sequencer #(
  parameter int TICK_CYCLES = `ARS_TICK_CYCLES
) (
  input  logic              ref_clk,
  input  logic              rst_b,
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [7:0]        paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  logic              driveTripped,
  input  logic [15:0]       tripCause,
  input  logic              errorsPresent,
  input  logic              remoteSeqComms,
  input  logic              faultResetDone,
  output logic              tripResetReq,
  output logic              restartReq,
  output logic              restartScheduledFlag,
  output logic              restartInProgressFlag,
  output logic [3:0]        triesRemaining,
  output ars_pkg::ars_dly_t waitRemaining,
  output logic              irq
);
  import ars_pkg::*;

  function automatic logic [3:0] clampLimit(input logic [3:0] v);
    clampLimit = (v < `ARS_LIM_MIN) ? `ARS_LIM_MIN : (v > `ARS_LIM_MAX) ? `ARS_LIM_MAX : v;
  endfunction

  function automatic ars_dly_t clampDly(input ars_dly_t v);
    clampDly = (v > `ARS_DLY_MAX) ? `ARS_DLY_MAX : v;
  endfunction

  ars_tmr_if tmr ();

  ars_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_b  (rst_b),
    .tb     (tmr)
  );

  ars_wait_timer u_wait (
    .ref_clk(ref_clk),
    .rst_b  (rst_b),
    .tb     (tmr)
  );

  // Software settings.
  logic        restartFeatureOn_q;
  logic [3:0]  restartTryLimit_q;
  logic [15:0] tripMaskOne_q;
  logic [15:0] tripMaskTwo_q;
  ars_dly_t    firstWaitSetOne_q;
  ars_dly_t    retryWaitSetOne_q;
  ars_dly_t    firstWaitSetTwo_q;
  ars_dly_t    retryWaitSetTwo_q;
  logic [2:0]  irqStat_q;
  logic [2:0]  irqStat_d;
  logic [2:0]  irqMask_q;

  // Sequencer state.
  ars_state_t  state_q;
  ars_state_t  state_d;
  logic [3:0]  attemptCnt_q;
  logic [3:0]  attemptCnt_d;
  logic        useSetOne_q;
  logic        firstTry_q;
  logic [14:0] freeRun_q;

  // Registered outputs.
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        tripResetReq_q;
  logic        restartReq_q;
  logic        scheduled_q;
  logic        inProgress_q;
  logic [3:0]  triesRemaining_q;
  logic        irq_q;

  // APB decode.
  logic        setupPh;
  logic        wrEn;
  logic        hitCtrl;
  logic        hitMask1;
  logic        hitMask2;
  logic        hitFirst1;
  logic        hitRetry1;
  logic        hitFirst2;
  logic        hitRetry2;
  logic        hitStatus;
  logic        hitTLeft;
  logic        hitIStat;
  logic        hitIMask;
  logic        addrHit;
  logic [31:0] ctrlRd;
  logic [31:0] statusRd;
  logic [31:0] rdMux;

  assign setupPh   = psel & ~penable;
  assign wrEn      = psel & penable & pwrite;
  assign hitCtrl   = (paddr == `ARS_CTRL_OFF);
  assign hitMask1  = (paddr == `ARS_MASK1_OFF);
  assign hitMask2  = (paddr == `ARS_MASK2_OFF);
  assign hitFirst1 = (paddr == `ARS_FIRST1_OFF);
  assign hitRetry1 = (paddr == `ARS_RETRY1_OFF);
  assign hitFirst2 = (paddr == `ARS_FIRST2_OFF);
  assign hitRetry2 = (paddr == `ARS_RETRY2_OFF);
  assign hitStatus = (paddr == `ARS_STATUS_OFF);
  assign hitTLeft  = (paddr == `ARS_TLEFT_OFF);
  assign hitIStat  = (paddr == `ARS_ISTAT_OFF);
  assign hitIMask  = (paddr == `ARS_IMASK_OFF);
  assign addrHit   = hitCtrl | hitMask1 | hitMask2 | hitFirst1 | hitRetry1 | hitFirst2 | hitRetry2 |
                     hitStatus | hitTLeft | hitIStat | hitIMask;

  assign ctrlRd   = 32'(restartFeatureOn_q) | (32'(restartTryLimit_q) << `ARS_CTRL_LIM_LSB);
  assign statusRd = {20'h0_0000, attemptCnt_q, triesRemaining_q, 2'b00, inProgress_q, scheduled_q};
  assign rdMux    = hitCtrl   ? ctrlRd :
                    hitMask1  ? {16'h0000, tripMaskOne_q} :
                    hitMask2  ? {16'h0000, tripMaskTwo_q} :
                    hitFirst1 ? {19'h0_0000, firstWaitSetOne_q} :
                    hitRetry1 ? {19'h0_0000, retryWaitSetOne_q} :
                    hitFirst2 ? {19'h0_0000, firstWaitSetTwo_q} :
                    hitRetry2 ? {19'h0_0000, retryWaitSetTwo_q} :
                    hitStatus ? statusRd :
                    hitTLeft  ? {19'h0_0000, tmr.remaining} :
                    hitIStat  ? {29'h0000_0000, irqStat_q} :
                    hitIMask  ? {29'h0000_0000, irqMask_q} : 32'h0000_0000;

  // Read data and error are captured in the setup cycle, so every access completes without wait states.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q  <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (setupPh) begin
        prdata_q  <= rdMux;
        pslverr_q <= ~addrHit;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      restartFeatureOn_q <= 1'b0;
      restartTryLimit_q  <= `ARS_LIM_RST;
      irqMask_q          <= 3'h0;
    end else if (wrEn && hitCtrl) begin
      restartFeatureOn_q <= pwdata[`ARS_CTRL_EN_BIT];
      restartTryLimit_q  <= pwdata[`ARS_CTRL_LIM_LSB +: 4];
    end else if (wrEn && hitIMask) begin
      irqMask_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tripMaskOne_q <= 16'h0000;
      tripMaskTwo_q <= 16'h0000;
    end else begin
      if (wrEn && hitMask1) tripMaskOne_q <= pwdata[15:0];
      if (wrEn && hitMask2) tripMaskTwo_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      firstWaitSetOne_q <= '0;
      retryWaitSetOne_q <= '0;
      firstWaitSetTwo_q <= '0;
      retryWaitSetTwo_q <= '0;
    end else begin
      if (wrEn && hitFirst1) firstWaitSetOne_q <= pwdata[12:0];
      if (wrEn && hitRetry1) retryWaitSetOne_q <= pwdata[12:0];
      if (wrEn && hitFirst2) firstWaitSetTwo_q <= pwdata[12:0];
      if (wrEn && hitRetry2) retryWaitSetTwo_q <= pwdata[12:0];
    end
  end

  // Trip selection and arming.
  logic       armed;
  logic       selOne;
  logic       selTwo;
  logic       selAny;
  logic [3:0] limEff;
  logic       exhausted;
  logic       pickOne;
  logic       pickFirst;
  ars_dly_t   dlyPick;

  assign armed     = restartFeatureOn_q & ~remoteSeqComms;
  assign selOne    = |(tripCause & tripMaskOne_q);
  assign selTwo    = |(tripCause & tripMaskTwo_q);
  assign selAny    = selOne | selTwo;
  assign limEff    = clampLimit(restartTryLimit_q);
  assign exhausted = (attemptCnt_q >= limEff);
  // In idle the live selection is used so the first load already carries the right delay.
  assign pickOne   = (state_q == ARS_IDLE) ? selOne : useSetOne_q;
  assign pickFirst = (state_q == ARS_IDLE) ? (attemptCnt_q == 4'h0) : firstTry_q;
  assign dlyPick   = pickOne ? (pickFirst ? firstWaitSetOne_q : retryWaitSetOne_q) :
                               (pickFirst ? firstWaitSetTwo_q : retryWaitSetTwo_q);

  // The wait restarts from full length for as long as any error is still present.
  assign tmr.load    = (state_q == ARS_IDLE) || (state_q == ARS_TIMING && errorsPresent);
  assign tmr.loadVal = clampDly(dlyPick);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ARS_IDLE: begin
        if (armed && driveTripped && selAny) begin
          state_d = exhausted ? ARS_LOCKOUT : ARS_TIMING;
        end
      end
      ARS_TIMING: begin
        if (!armed || !driveTripped) begin
          state_d = ARS_IDLE;
        end else if (!errorsPresent && !tmr.load && tmr.remaining == '0) begin
          state_d = ARS_RESTART;
        end
      end
      ARS_RESTART: begin
        if (!driveTripped || !armed) begin
          state_d = ARS_IDLE;
        end
      end
      ARS_LOCKOUT: begin
        if (faultResetDone) begin
          state_d = ARS_IDLE;
        end
      end
      default: state_d = ARS_IDLE;
    endcase
  end

  logic doRestart;
  logic enterLock;
  logic freeClear;
  logic freeHold;
  logic [14:0] retryX4;
  logic [14:0] freeThr;

  assign doRestart = (state_q == ARS_TIMING) && (state_d == ARS_RESTART);
  assign enterLock = (state_q != ARS_LOCKOUT) && (state_d == ARS_LOCKOUT);
  assign retryX4   = {clampDly(retryWaitSetOne_q), 2'b00};
  assign freeThr   = (retryX4 > `ARS_FREE_TICKS) ? retryX4 : `ARS_FREE_TICKS;
  assign freeHold  = driveTripped || (state_q != ARS_IDLE);
  assign freeClear = !freeHold && (freeRun_q >= freeThr) && (attemptCnt_q != 4'h0);

  // A successful external reset outranks a restart counted in the same cycle.
  assign attemptCnt_d = (faultResetDone || freeClear) ? 4'h0 :
                        doRestart ? attemptCnt_q + 4'h1 : attemptCnt_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ARS_IDLE;
      attemptCnt_q <= 4'h0;
      useSetOne_q  <= 1'b0;
      firstTry_q   <= 1'b0;
    end else begin
      state_q      <= state_d;
      attemptCnt_q <= attemptCnt_d;
      if (state_q == ARS_IDLE) begin
        useSetOne_q <= selOne;
        firstTry_q  <= (attemptCnt_q == 4'h0);
      end
    end
  end

  // Trip-free time is counted in ticks, so its length follows the same timebase as the delays.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      freeRun_q <= '0;
    end else if (freeHold) begin
      freeRun_q <= '0;
    end else if (tmr.tick && freeRun_q < freeThr) begin
      freeRun_q <= freeRun_q + 15'h0001;
    end
  end

  logic [2:0] irqEvents;
  assign irqEvents = {freeClear, enterLock, doRestart};
  // A new event wins over a write-one-to-clear in the same cycle.
  assign irqStat_d = (irqStat_q & ~((wrEn && hitIStat) ? pwdata[2:0] : 3'h0)) | irqEvents;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_q        <= 3'h0;
      irq_q            <= 1'b0;
      tripResetReq_q   <= 1'b0;
      restartReq_q     <= 1'b0;
      scheduled_q      <= 1'b0;
      inProgress_q     <= 1'b0;
      triesRemaining_q <= `ARS_LIM_RST;
    end else begin
      irqStat_q        <= irqStat_d;
      irq_q            <= |(irqStat_d & irqMask_q);
      tripResetReq_q   <= doRestart;
      restartReq_q     <= doRestart;
      scheduled_q      <= (state_d == ARS_TIMING);
      inProgress_q     <= (state_d == ARS_RESTART);
      triesRemaining_q <= (attemptCnt_d >= limEff) ? 4'h0 : limEff - attemptCnt_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign tripResetReq          = tripResetReq_q;
  assign restartReq            = restartReq_q;
  assign restartScheduledFlag  = scheduled_q;
  assign restartInProgressFlag = inProgress_q;
  assign triesRemaining        = triesRemaining_q;
  assign waitRemaining         = tmr.remaining;
  assign irq                   = irq_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_restart_armed: assert property (restartReq |-> $past(armed))
    else $error("restart issued while disabled");
  a_restart_counts: assert property (restartReq |-> attemptCnt_q == $past(attemptCnt_q) + 4'h1 ||
                                     $past(faultResetDone))
    else $error("restart not counted");
  a_limit_kept: assert property (restartReq |-> attemptCnt_q <= $past(limEff))
    else $error("restart beyond attempt limit");
  a_reset_clears: assert property (faultResetDone |=> attemptCnt_q == 4'h0)
    else $error("fault reset did not clear count");
  a_remote_inhibit: assert property (remoteSeqComms |=> !restartReq && state_q != ARS_TIMING)
    else $error("restart activity in remote comms mode");
  a_pending_before: assert property (restartReq |-> $past(restartScheduledFlag) && restartInProgressFlag)
    else $error("restart without pending phase");
  a_progress_flag: assert property (restartReq |-> restartInProgressFlag && !restartScheduledFlag)
    else $error("restart flag missing");
  a_unselected_trip: assert property (state_q == ARS_IDLE && !selAny |=> state_q == ARS_IDLE)
    else $error("unselected trip started sequence");
  a_time_held: assert property (state_q == ARS_TIMING && !tmr.load && !tmr.tick ##1 state_q == ARS_TIMING
                                && !tmr.load |-> $stable(waitRemaining))
    else $error("remaining wait changed without tick");
  a_errors_wait: assert property (restartReq |-> $past(!errorsPresent, 1) && $past(waitRemaining) == '0)
    else $error("restart before wait elapsed");
  a_tries_left: assert property (##1 (triesRemaining == 4'h0 && attemptCnt_q >= $past(limEff)) ||
                                 (5'(triesRemaining) + 5'(attemptCnt_q) == 5'($past(limEff))))
    else $error("attempts left wrong");

  c_restart:  cover property (restartReq);
  c_lockout:  cover property (state_q == ARS_LOCKOUT ##1 faultResetDone);
  c_freerun:  cover property (freeClear);
  c_set_two:  cover property (doRestart && !useSetOne_q);
endmodule

// ---- hw/ars_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the auto restart sequencer.
`ifndef ARS_REGS_SVH
`define ARS_REGS_SVH
`define ARS_CTRL_OFF      8'h00
`define ARS_MASK1_OFF     8'h04
`define ARS_MASK2_OFF     8'h08
`define ARS_FIRST1_OFF    8'h0c
`define ARS_RETRY1_OFF    8'h10
`define ARS_FIRST2_OFF    8'h14
`define ARS_RETRY2_OFF    8'h18
`define ARS_STATUS_OFF    8'h1c
`define ARS_TLEFT_OFF     8'h20
`define ARS_ISTAT_OFF     8'h24
`define ARS_IMASK_OFF     8'h28
`define ARS_CTRL_EN_BIT   0
`define ARS_CTRL_LIM_LSB  4
`define ARS_LIM_RST       4'h1
`define ARS_LIM_MIN       4'h1
`define ARS_LIM_MAX       4'ha
`define ARS_DLY_MAX       13'h1770
`define ARS_EV_RESTART    0
`define ARS_EV_LOCKOUT    1
`define ARS_EV_CLEARED    2
`define ARS_CLK_NS        20
`define ARS_TICK_NS       100000000
`define ARS_TICK_CYCLES   (`ARS_TICK_NS / `ARS_CLK_NS)
`define ARS_FREE_RUN_S    300
`define ARS_TICKS_PER_S   10
`define ARS_FREE_TICKS    15'(`ARS_FREE_RUN_S * `ARS_TICKS_PER_S)
`endif

// ---- hw/ars_pkg.sv ----
// Types shared by the auto restart sequencer modules.
package ars_pkg;
  typedef enum logic [1:0] {
    ARS_IDLE    = 2'b00,
    ARS_TIMING  = 2'b01,
    ARS_RESTART = 2'b10,
    ARS_LOCKOUT = 2'b11
  } ars_state_t;
  typedef logic [12:0] ars_dly_t;
endpackage

// ---- hw/ars_tmr_if.sv ----
// Timebase tick and wait countdown signals shared between the sequencer and its helpers.
interface ars_tmr_if;
  logic             tick;
  logic             load;
  ars_pkg::ars_dly_t loadVal;
  ars_pkg::ars_dly_t remaining;
  modport gen (output tick);
  modport tmr (input tick, input load, input loadVal, output remaining);
  modport ctl (input tick, output load, output loadVal, input remaining);
endinterface

// ---- hw/ars_tick_gen.sv ----
// Divider that makes the 0.1 s timebase tick from the system clock.
`include "ars_regs.svh"
module ars_tick_gen #(
  parameter int TICK_CYCLES = `ARS_TICK_CYCLES
) (
  input logic  ref_clk,
  input logic  rst_b,
  ars_tmr_if.gen tb
);
  localparam int CW = $clog2(TICK_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] divCnt_q;
  logic          tick_q;

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= '0;
      tick_q   <= 1'b0;
    end else begin
      divCnt_q <= (divCnt_q == LAST) ? '0 : divCnt_q + 1'b1;
      tick_q   <= (divCnt_q == LAST);
    end
  end

  assign tb.tick = tick_q;
endmodule

// ---- hw/ars_wait_timer.sv ----
// Countdown of the restart wait in timebase ticks.
module ars_wait_timer (
  input logic  ref_clk,
  input logic  rst_b,
  ars_tmr_if.tmr tb
);
  import ars_pkg::*;

  ars_dly_t remaining_q;

  // A loaded value is changed only by the countdown or by a new load, so setting edits reach it at the next load.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remaining_q <= '0;
    end else if (tb.load) begin
      remaining_q <= tb.loadVal;
    end else if (tb.tick && remaining_q != '0) begin
      remaining_q <= remaining_q - 1'b1;
    end
  end

  assign tb.remaining = remaining_q;
endmodule

// ---- dv/ars_drive_model.sv ----
// Behavioural drive trip source that answers the sequencer's trip reset request.
module ars_drive_model (
  input  logic        ref_clk,
  input  logic        rst_b,
  input  logic        tripGo,
  input  logic [15:0] tripBits,
  input  logic [7:0]  errCycles,
  input  logic [3:0]  resetLag,
  input  logic        tripResetReq,
  input  logic        faultResetDone,
  output logic        driveTripped,
  output logic [15:0] tripCause,
  output logic        errorsPresent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] errCnt;
  logic [3:0] lagCnt;
  logic       lagRun;
  // The cause is only valid while tripped, so it toggles otherwise and a stale read shows up.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      driveTripped  <= 1'b0;
      tripCause     <= 16'h0000;
      errorsPresent <= 1'b0;
      errCnt        <= 8'h00;
      lagCnt        <= 4'h0;
      lagRun        <= 1'b0;
    end else if (tripGo) begin
      driveTripped  <= 1'b1;
      tripCause     <= tripBits;
      errorsPresent <= 1'b1;
      errCnt        <= errCycles;
      lagRun        <= 1'b0;
    end else begin
      if (errCnt != 8'h00) begin
        errCnt <= errCnt - 8'h01;
      end else begin
        errorsPresent <= 1'b0;
      end
      if (faultResetDone) begin
        driveTripped <= 1'b0;
      end
      // A slow drive leaves the tripped state resetLag plus one cycles after the request is seen.
      if (tripResetReq) begin
        lagRun <= 1'b1;
        lagCnt <= resetLag;
      end else if (lagRun && lagCnt == 4'h0) begin
        driveTripped <= 1'b0;
        lagRun       <= 1'b0;
      end else if (lagRun) begin
        lagCnt <= lagCnt - 4'h1;
      end
      if (!driveTripped) begin
        tripCause <= ~tripCause;
      end
    end
  end
endmodule

// ---- dv/ars_sequencer_tb.sv ----
// Self-checking testbench of the auto restart sequencer.
`include "ars_regs.svh"
module ars_sequencer_tb import ars_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 4;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, er;
  logic        tripGo = 1'b0, remoteSeqComms = 1'b0, faultResetDone = 1'b0;
  logic [15:0] tripBits = 16'h0000;
  logic [7:0]  errCycles = 8'h05;
  logic [3:0]  resetLag = 4'h0;
  logic        driveTripped, errorsPresent, tripResetReq, restartReq;
  logic        restartScheduledFlag, restartInProgressFlag;
  logic [15:0] tripCause;
  logic [3:0]  triesRemaining;
  ars_dly_t    waitRemaining;
  logic [31:0] seed = 32'h326b, rd, v;
  int          errCount = 0, checksDone = 0, tries = 0, n;
  int          b1, b2, bb, bn, f1, r1, f2, r2;

  ars_sequencer #(.TICK_CYCLES(TC)) i_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .driveTripped, .tripCause, .errorsPresent, .remoteSeqComms, .faultResetDone, .tripResetReq,
    .restartReq, .restartScheduledFlag, .restartInProgressFlag, .triesRemaining, .waitRemaining, .irq);
  ars_drive_model i_drive (.ref_clk, .rst_b, .tripGo, .tripBits, .errCycles, .resetLag, .tripResetReq,
    .faultResetDone, .driveTripped, .tripCause, .errorsPresent);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    errCount++;
    $display("mismatch at %0t: %s timed out", $time, what);
    printVerdict();
  endtask

  // Master holds the whole request until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic runTrip(input logic [15:0] bits, input int dly, input logic go);
    int lim;
    @(posedge ref_clk);
    tripGo <= 1'b1;
    tripBits <= bits;
    errCycles <= 8'(5 + nextRand() % 8);
    resetLag <= 4'(nextRand() % 4);
    @(posedge ref_clk);
    tripGo <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(32'(restartScheduledFlag), 32'(go), "scheduled flag");
    repeat (2) @(negedge ref_clk);
    if (go) chk(32'(waitRemaining), 32'(dly), "time left");
    n = 0;
    while (errorsPresent !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (errorsPresent !== 1'b0) timeout("errors clear");
    lim = go ? (dly + 2) * TC + 10 : 80;
    n = 0;
    while (restartReq !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (go) begin
      chk(32'(n >= (dly - 1) * TC && n <= (dly + 1) * TC + 4), 32'h1, "restart delay");
      chk(32'(tripResetReq), 32'h1, "trip reset pulse");
      chk(32'(restartInProgressFlag), 32'h1, "in progress flag");
      tries--;
      n = 0;
      while ((driveTripped !== 1'b0 || restartInProgressFlag !== 1'b0) && n < 50) begin
        @(negedge ref_clk);
        n++;
      end
      if (n >= 50) timeout("drive restart");
    end else begin
      chk(32'(restartReq | restartInProgressFlag), 32'h0, "no restart");
    end
    chk(32'(triesRemaining), 32'(tries), "tries left");
    $display("trip test done at %0t", $time);
  endtask

  task automatic faultReset(input int lim);
    @(posedge ref_clk);
    faultResetDone <= 1'b1;
    @(posedge ref_clk);
    faultResetDone <= 1'b0;
    tries = lim;
    repeat (3) @(negedge ref_clk);
    chk(32'(triesRemaining), 32'(tries), "count cleared");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk(32'(triesRemaining), 32'h1, "reset tries");
    apb(1'b0, `ARS_CTRL_OFF, 32'h0);
    chk(rd, 32'h10, "control reset");
    apb(1'b0, 8'h2c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'hffffffff : nextRand();
      apb(1'b1, `ARS_MASK1_OFF, v);
      apb(1'b0, `ARS_MASK1_OFF, 32'h0);
      chk(rd, {16'h0000, v[15:0]}, "mask readback");
    end
    b1 = nextRand() % 4;
    b2 = 4 + nextRand() % 4;
    bb = 8 + nextRand() % 4;
    bn = 12 + nextRand() % 4;
    f1 = nextRand() % 4;
    r1 = f1 + 4;
    f2 = r1 + 4;
    r2 = f2 + 4;
    apb(1'b1, `ARS_MASK1_OFF, (32'h1 << b1) | (32'h1 << bb));
    apb(1'b1, `ARS_MASK2_OFF, (32'h1 << b2) | (32'h1 << bb));
    apb(1'b1, `ARS_FIRST1_OFF, 32'(f1));
    apb(1'b1, `ARS_RETRY1_OFF, 32'(r1));
    apb(1'b1, `ARS_FIRST2_OFF, 32'(f2));
    apb(1'b1, `ARS_RETRY2_OFF, 32'(r2));
    apb(1'b1, `ARS_IMASK_OFF, 32'h0);
    apb(1'b1, `ARS_CTRL_OFF, 32'h30);
    tries = 3;
    runTrip(16'h1 << b1, f1, 1'b0);
    faultReset(3);
    apb(1'b1, `ARS_CTRL_OFF, 32'h31);
    runTrip(16'h1 << b1, f1, 1'b1);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, `ARS_IMASK_OFF, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk(32'(irq), 32'h1, "irq raised");
    apb(1'b0, `ARS_ISTAT_OFF, 32'h0);
    chk(rd, 32'h1, "restart event");
    apb(1'b1, `ARS_ISTAT_OFF, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk(32'(irq), 32'h0, "irq cleared");
    runTrip(16'h1 << b1, r1, 1'b1);
    runTrip(16'h1 << bb, r1, 1'b1);
    runTrip(16'h1 << b1, 0, 1'b0);
    faultReset(3);
    runTrip(16'h1 << b2, f2, 1'b1);
    runTrip(16'h1 << b2, r2, 1'b1);
    runTrip(16'h1 << bn, 0, 1'b0);
    faultReset(3);
    @(posedge ref_clk);
    remoteSeqComms <= 1'b1;
    runTrip(16'h1 << b1, 0, 1'b0);
    faultReset(3);
    @(posedge ref_clk);
    remoteSeqComms <= 1'b0;
    runTrip(16'h1 << bb, f1, 1'b1);
    n = 0;
    while (triesRemaining !== 4'h3 && n < 3000 * TC + 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(n >= 3000 * TC - 40 && n < 3000 * TC + 200), 32'h1, "trip free clear");
    apb(1'b0, `ARS_STATUS_OFF, 32'h0);
    chk(rd, 32'h30, "status after clear");
    apb(1'b0, `ARS_ISTAT_OFF, 32'h0);
    chk(rd, 32'h7, "event status");
    @(negedge ref_clk);
    chk(32'(irq), 32'h1, "irq pending");
    $display("trip free test done at %0t", $time);
    printVerdict();
  end
endmodule
